// *** inc/csl_pkg.sv ***
// Constants, address map and enumerations of the code security lock
`default_nettype none
package csl_pkg;
   localparam int          ADDR_W      = 22;
   localparam int          DATA_W      = 16;
   localparam int          KEY_WORDS   = 8;
   localparam int          IDX_W       = 3;
   // Password words in flash
   localparam logic [21:0] PWD_FIRST   = 22'h3f7ff8;
   localparam logic [21:0] PWD_LAST    = 22'h3f7fff;
   // One-time-programmable block, 1K words
   localparam logic [21:0] OTP_FIRST   = 22'h3d7800;
   localparam logic [21:0] OTP_LAST    = 22'h3d7bff;
   // Flash array and the two low single-access RAM blocks
   localparam logic [21:0] FLASH_FIRST = 22'h3d8000;
   localparam logic [21:0] FLASH_LAST  = 22'h3f7fff;
   localparam logic [21:0] LSB0_FIRST  = 22'h008000;
   localparam logic [21:0] LSB0_LAST   = 22'h008fff;
   localparam logic [21:0] LSB1_FIRST  = 22'h009000;
   localparam logic [21:0] LSB1_LAST   = 22'h009fff;
   // Fixed password read timing, in wait-state cycles
   localparam logic [4:0]  PWD_WAIT    = 5'h10;
   localparam logic [4:0]  CNT_RESET   = 5'h00;
   localparam logic [2:0]  IDX_RESET   = 3'h0;
   localparam logic [15:0] WORD_ZERO   = 16'h0000;

   typedef enum logic [1:0] {
      CSL_SRC_CPU,
      CSL_SRC_DEBUG,
      CSL_SRC_EXTERN,
      CSL_SRC_BOOT
   } csl_src_t;

   typedef enum logic [1:0] {
      CSL_IDLE,
      CSL_FETCH
   } csl_state_t;
endpackage : csl_pkg
`default_nettype wire

// *** hdl/csl_key_mem.sv ***
// Eight-word key store with registered read data
`default_nettype none
module csl_key_mem (
   // Clock and reset
   input  wire logic                         clock_i,
   input  wire logic                         nrst_i,
   // Write port
   input  wire logic                         wr_i,
   input  wire logic [csl_pkg::IDX_W-1:0]    wr_addr_i,
   input  wire logic [csl_pkg::DATA_W-1:0]   wr_data_i,
   // Read port
   input  wire logic [csl_pkg::IDX_W-1:0]    rd_addr_i,
   output logic      [csl_pkg::DATA_W-1:0]   rd_data_o
);
   import csl_pkg::*;

   logic [DATA_W-1:0] mem [KEY_WORDS];

   // Cleared on reset so a stale key never survives into a new session
   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < KEY_WORDS; i++) begin
            mem[i] <= WORD_ZERO;
         end
         rd_data_o <= WORD_ZERO;
      end else begin
         if (wr_i) begin
            mem[wr_addr_i] <= wr_data_i;
         end
         rd_data_o <= mem[rd_addr_i];
      end
   end
endmodule : csl_key_mem
`default_nettype wire

// *** hdl/csl_lock.sv ***
// Code security lock: key compare against flash password and secure-access guard
//
// What this block does
// R01: Password is eight flash words from 0x3F7FF8 to 0x3F7FFF.
// R02: Password words are read with a fixed 16 wait-state timing.
// R03: One guard checks every flash, OTP and low RAM block access.
// R04: OTP block is 1K words from 0x3D7800 to 0x3D7BFF, secure.
// R05: Locked: debug port reads of secure memory return no contents.
// R06: Locked: external-code or boot-loader reads of secure memory are refused.
// R07: Full 128-bit key must equal stored password to unlock.
// R08: All-zero password is a permanent lock; no key opens it.
// R09: Key words arrive through the peripheral frame zero write strobe.
// R10: Reset leaves the block locked until a matching compare completes.
`default_nettype none
module csl_lock (
   // Clock and reset
   input  wire logic                         clock_i,
   input  wire logic                         nrst_i,
   // Key write strobe
   input  wire logic                         key_wr_i,
   input  wire logic [csl_pkg::IDX_W-1:0]    key_idx_i,
   input  wire logic [csl_pkg::DATA_W-1:0]   key_data_i,
   // Unlock control and status
   input  wire logic                         unlock_req_i,
   output logic                              busy_o,
   output logic                              unlocked_o,
   // Password read from flash
   output logic                              pwd_rd_o,
   output logic      [csl_pkg::ADDR_W-1:0]   pwd_addr_o,
   input  wire logic [csl_pkg::DATA_W-1:0]   pwd_data_i,
   // Memory access check
   input  wire logic                         acc_valid_i,
   input  wire logic [csl_pkg::ADDR_W-1:0]   acc_addr_i,
   input  wire csl_pkg::csl_src_t            acc_src_i,
   input  wire logic [csl_pkg::DATA_W-1:0]   mem_data_i,
   output logic                              acc_ok_o,
   output logic                              acc_deny_o,
   output logic      [csl_pkg::DATA_W-1:0]   acc_data_o
);
   import csl_pkg::*;

   csl_state_t        state;
   csl_state_t        next_state;
   logic [IDX_W-1:0]  idx;
   logic [IDX_W-1:0]  next_idx;
   logic [4:0]        cnt;
   logic [4:0]        next_cnt;
   logic              match;
   logic              next_match;
   logic              nonzero;
   logic              next_nonzero;
   logic              unlocked;
   logic              next_unlocked;
   logic [DATA_W-1:0] key_word;
   logic              sample;
   logic              fin;
   logic              fin_ok;

   csl_key_mem u_key_mem (
      .clock_i   (clock_i),
      .nrst_i    (nrst_i),
      .wr_i      (key_wr_i),
      .wr_addr_i (key_idx_i),
      .wr_data_i (key_data_i),
      .rd_addr_i (idx),
      .rd_data_o (key_word)
   );

   assign sample = (state == CSL_FETCH) && (cnt == PWD_WAIT);
   assign fin    = sample && (idx == IDX_W'(KEY_WORDS - 1));
   assign fin_ok = fin && match && (pwd_data_i == key_word)
                   && (nonzero || (pwd_data_i != WORD_ZERO));  // R08

   // Compare sequencer
   always_comb begin
      next_state    = state;
      next_idx      = idx;
      next_cnt      = cnt;
      next_match    = match;
      next_nonzero  = nonzero;
      next_unlocked = unlocked;
      case (state)
         CSL_IDLE: begin
            if (unlock_req_i) begin
               next_state    = CSL_FETCH;
               next_idx      = IDX_RESET;
               next_cnt      = CNT_RESET;
               next_match    = 1'b1;
               next_nonzero  = 1'b0;
               next_unlocked = 1'b0;                           // R10
            end
         end
         CSL_FETCH: begin
            next_unlocked = 1'b0;
            if (sample) begin                                  // R02
               next_cnt     = CNT_RESET;
               next_idx     = idx + IDX_W'(1);
               next_match   = match && (pwd_data_i == key_word);  // R07
               next_nonzero = nonzero || (pwd_data_i != WORD_ZERO);
               if (fin) begin
                  next_state    = CSL_IDLE;
                  next_unlocked = fin_ok;                      // R07
               end
            end else begin
               next_cnt = cnt + 5'h01;
            end
         end
         default: begin
            next_state    = CSL_IDLE;
            next_unlocked = 1'b0;
         end
      endcase
      // A fresh key invalidates any earlier grant
      if (key_wr_i) begin                                      // R09
         next_unlocked = 1'b0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         state    <= CSL_IDLE;
         idx      <= IDX_RESET;
         cnt      <= CNT_RESET;
         match    <= 1'b0;
         nonzero  <= 1'b0;
         unlocked <= 1'b0;                                     // R10
      end else begin
         state    <= next_state;
         idx      <= next_idx;
         cnt      <= next_cnt;
         match    <= next_match;
         nonzero  <= next_nonzero;
         unlocked <= next_unlocked;
      end
   end

   assign busy_o     = (state == CSL_FETCH);
   assign unlocked_o = unlocked;
   assign pwd_rd_o   = (state == CSL_FETCH);
   assign pwd_addr_o = PWD_FIRST + ADDR_W'(idx);               // R01

   // Access guard
   logic              in_otp;
   logic              in_flash;
   logic              in_lsb0;
   logic              in_lsb1;
   logic              secure;
   logic              refuse;
   logic              next_ok;
   logic              next_deny;
   logic [DATA_W-1:0] next_data;

   always_comb begin
      in_otp    = (acc_addr_i >= OTP_FIRST) && (acc_addr_i <= OTP_LAST);      // R04
      in_flash  = (acc_addr_i >= FLASH_FIRST) && (acc_addr_i <= FLASH_LAST);
      in_lsb0   = (acc_addr_i >= LSB0_FIRST) && (acc_addr_i <= LSB0_LAST);
      in_lsb1   = (acc_addr_i >= LSB1_FIRST) && (acc_addr_i <= LSB1_LAST);
      secure    = in_otp || in_flash || in_lsb0 || in_lsb1;                   // R03
      // Code running inside secure memory may always read it
      refuse    = secure && !unlocked && (acc_src_i != CSL_SRC_CPU);         // R05 R06
      next_ok   = acc_valid_i && !refuse;
      next_deny = acc_valid_i && refuse;
      // Refused reads return zero so no stored bit leaks
      next_data = next_ok ? mem_data_i : WORD_ZERO;                          // R05
   end

   always_ff @(posedge clock_i) begin
      if (!nrst_i) begin
         acc_ok_o   <= 1'b0;
         acc_deny_o <= 1'b0;
         acc_data_o <= WORD_ZERO;
      end else begin
         acc_ok_o   <= next_ok;
         acc_deny_o <= next_deny;
         acc_data_o <= next_data;
      end
   end

   // Checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);

   sequence s_word_start;
      (state == CSL_FETCH) && (cnt == CNT_RESET);
   endsequence

   sequence s_word_sample;
      ##16 sample ##1 !sample;
   endsequence

   a_reset_locked: assert property ($rose(nrst_i) |-> !unlocked_o)            // R10
      else $error("block not locked after reset");

   a_wait_fixed: assert property (s_word_start |-> s_word_sample)             // R02
      else $error("password word not sampled after 16 wait cycles");

   a_pwd_window: assert property (pwd_rd_o |->
      (pwd_addr_o >= PWD_FIRST) && (pwd_addr_o <= PWD_LAST))                  // R01
      else $error("password read outside password words");

   a_debug_refused: assert property (acc_valid_i && !unlocked_o
      && (acc_src_i == CSL_SRC_DEBUG) && (acc_addr_i == OTP_FIRST)
      |=> acc_deny_o && !acc_ok_o && (acc_data_o == WORD_ZERO))              // R05
      else $error("locked debug read of OTP was not refused");

   a_extern_refused: assert property (acc_valid_i && !unlocked_o
      && (acc_src_i inside {CSL_SRC_EXTERN, CSL_SRC_BOOT})
      && (acc_addr_i == LSB1_LAST) |=> acc_deny_o)                            // R06
      else $error("locked external read of low RAM was not refused");

   a_deny_blank: assert property (acc_deny_o |-> acc_data_o == WORD_ZERO)   // R05
      else $error("refused read returned data");

   a_guard_cpu: assert property (acc_valid_i && (acc_src_i == CSL_SRC_CPU)
      |=> acc_ok_o && (acc_data_o == $past(mem_data_i)))                      // R03
      else $error("secure code read was blocked or altered");

   a_unlock_cause: assert property ($rose(unlocked_o) |-> $past(fin_ok))      // R07
      else $error("unlocked without a full matching compare");

   a_zero_pwd: assert property (fin && !nonzero && (pwd_data_i == WORD_ZERO)
      |=> !unlocked_o)                                                        // R08
      else $error("all-zero password opened the lock");

   a_key_relocks: assert property (key_wr_i |=> !unlocked_o)                 // R09
      else $error("key write left the block unlocked");

   a_fetch_locked: assert property (busy_o |-> !unlocked_o)                  // R10
      else $error("unlocked while comparing");
endmodule : csl_lock
`default_nettype wire

// *** bench/csl_flash_model.sv ***
// Flash model that serves the eight password words to the lock
`default_nettype none
module csl_flash_model
   import csl_pkg::*;
(
   // Clock
   input  wire logic           clock_i,
   // Password read port
   input  wire logic           pwd_rd_i,
   input  wire logic [21:0]    pwd_addr_i,
   input  wire logic [127:0]   pwd_i,
   output logic      [15:0]    pwd_data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [21:0] last  = 22'h000000;
   logic [3:0]  cnt   = 4'h0;
   logic [15:0] noise = 16'h5a5a;
   always @(posedge clock_i) begin
      noise <= ~noise;
      last  <= pwd_addr_i;
      if (!pwd_rd_i || pwd_addr_i != last) begin
         cnt <= 4'h0;
      end else if (cnt != 4'h8) begin
         cnt <= cnt + 4'h1;
      end
   end
   // Data only settles well inside the wait window; a toggling value otherwise
   // A word that has just been addressed shows noise until its count has run again
   assign pwd_data_o = (pwd_rd_i && cnt == 4'h8 && pwd_addr_i == last
                        && pwd_addr_i >= PWD_FIRST)
                       ? pwd_i[16*pwd_addr_i[2:0] +: 16] : noise;
endmodule : csl_flash_model
`default_nettype wire

// *** bench/code_security_lock_test.sv ***
// Self-checking bench for the code security lock
`default_nettype none
module code_security_lock_test;
   import csl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        key_wr_i = 1'b0;
   logic [2:0]  key_idx_i = 3'h0;
   logic [15:0] key_data_i = 16'h0000;
   logic        unlock_req_i = 1'b0;
   logic        acc_valid_i = 1'b0;
   logic [21:0] acc_addr_i = 22'h000000;
   csl_src_t    acc_src_i = CSL_SRC_CPU;
   logic [15:0] mem_data_i = 16'h0000;
   logic        busy_o, unlocked_o, pwd_rd_o, acc_ok_o, acc_deny_o;
   logic [21:0] pwd_addr_o;
   logic [15:0] pwd_data_i, acc_data_o;
   logic [127:0] pwd = 128'h0;
   logic [127:0] key = 128'h0;
   logic        unl = 1'b0;
   integer      err_count = 0;
   integer      total_checks = 0;
   integer      seed = 99;

   always #4 clock_i = ~clock_i;

   csl_lock DUT (.clock_i(clock_i), .nrst_i(nrst_i), .key_wr_i(key_wr_i),
      .key_idx_i(key_idx_i), .key_data_i(key_data_i), .unlock_req_i(unlock_req_i),
      .busy_o(busy_o), .unlocked_o(unlocked_o), .pwd_rd_o(pwd_rd_o),
      .pwd_addr_o(pwd_addr_o), .pwd_data_i(pwd_data_i), .acc_valid_i(acc_valid_i),
      .acc_addr_i(acc_addr_i), .acc_src_i(acc_src_i), .mem_data_i(mem_data_i),
      .acc_ok_o(acc_ok_o), .acc_deny_o(acc_deny_o), .acc_data_o(acc_data_o));

   csl_flash_model flash (.clock_i(clock_i), .pwd_rd_i(pwd_rd_o), .pwd_addr_i(pwd_addr_o),
      .pwd_i(pwd), .pwd_data_o(pwd_data_i));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task results;
      $display("checks=%0d errors=%0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   // Back-to-back word writes; any write relocks until the next compare
   task write_key(input logic [127:0] k);
      for (int i = 0; i < 8; i++) begin
         @(posedge clock_i);
         key_wr_i <= 1'b1;
         key_idx_i <= i[2:0];
         key_data_i <= k[16*i +: 16];
      end
      @(posedge clock_i);
      key_wr_i <= 1'b0;
      key = k;
      unl = 1'b0;
      #1 check(unlocked_o, 0);
   endtask : write_key

   task unlock;
      int n;
      @(posedge clock_i);
      unlock_req_i <= 1'b1;
      @(posedge clock_i);
      unlock_req_i <= 1'b0;
      #1 n = 0;
      while (busy_o === 1'b1 && n < 300) begin
         check(pwd_addr_o, PWD_FIRST + n / 17);
         check(pwd_rd_o, 1);
         n++;
         @(posedge clock_i);
         #1;
      end
      unl = (key == pwd) && (pwd != 128'h0);
      check(n, 136);
      check(unlocked_o, unl);
   endtask : unlock

   task access(input logic [21:0] a, input csl_src_t s);
      logic [15:0] d;
      logic        sec;
      logic        deny;
      d = 16'($random(seed));
      sec = (a >= OTP_FIRST && a <= OTP_LAST) || (a >= FLASH_FIRST && a <= FLASH_LAST)
            || (a >= LSB0_FIRST && a <= LSB1_LAST);
      deny = sec && !unl && s != CSL_SRC_CPU;
      @(posedge clock_i);
      acc_valid_i <= 1'b1;
      acc_addr_i <= a;
      acc_src_i <= s;
      mem_data_i <= d;
      @(posedge clock_i);
      acc_valid_i <= 1'b0;
      #1 check({acc_ok_o, acc_deny_o}, {!deny, deny});
      check(acc_data_o, deny ? 16'h0000 : d);
   endtask : access

   // Outer boundaries of OTP, flash and the joined low RAM blocks, with the unguarded words just above OTP and on either side of the low RAM
   task sweep;
      logic [21:0] tbl [9] = '{OTP_FIRST, OTP_LAST, OTP_LAST + 22'h1, FLASH_FIRST,
         PWD_LAST, LSB0_FIRST, LSB1_LAST, LSB0_FIRST - 22'h1, LSB1_LAST + 22'h1};
      for (int s = 0; s < 4; s++) begin
         for (int j = 0; j < 9; j++) begin
            access(tbl[j], csl_src_t'(s));
         end
      end
   endtask : sweep

   initial begin
      repeat (8) @(posedge clock_i);
      nrst_i <= 1'b1;
      #1 check({busy_o, unlocked_o, pwd_rd_o}, 0);
      pwd = {$random(seed), $random(seed), $random(seed), $random(seed)};
      sweep;
      write_key(pwd);
      unlock;
      sweep;
      // Reset while open: the lock closes and the stored key is gone
      @(posedge clock_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      nrst_i <= 1'b1;
      unl = 1'b0;
      key = 128'h0;
      #1 check({busy_o, unlocked_o, pwd_rd_o}, 0);
      unlock;
      access(OTP_LAST, CSL_SRC_DEBUG);
      write_key(pwd ^ (128'h1 << 127));
      unlock;
      access(PWD_FIRST, CSL_SRC_DEBUG);
      pwd = 128'h0;
      write_key(128'h0);
      unlock;
      access(OTP_FIRST, CSL_SRC_BOOT);
      results;
   end

   initial begin
      #100000;
      err_count++;
      results;
   end
endmodule : code_security_lock_test
`default_nettype wire
